//--- include/clk_ctrl_pkg.sv
/*
 package for the clock source, sleep and reset control block.
 assumes a single 20 MHz reference clock; all other rates are enables.
*/
package clk_ctrl_pkg;
  // reference clock and timing
  localparam int unsigned REF_CLK_HZ = 20000000;
  localparam int unsigned REF_PERIOD_NS = 50;
  // least reset pulse width, rounded up to whole cycles, at least one
  localparam int unsigned RESET_MIN_NS = 50;
  localparam int unsigned RESET_MIN_CYC_RAW = (RESET_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_CYC_RAW < 1) ? 1 : RESET_MIN_CYC_RAW;
  // internal rc oscillator rate, made as an enable from the reference
  localparam int unsigned RC_OSC_HZ = 1000000;
  localparam int unsigned RC_DIV = REF_CLK_HZ / RC_OSC_HZ;
  // fuse values and sizes
  localparam logic FUSE_RESET = 1'b1;  // unprogrammed: external oscillator
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned PORT_WIDTH = 15;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_IDLE = 2'b01,
    ST_PWRDN = 2'b10
  } power_state_t;

  typedef enum logic [1:0] {
    SLEEP_NONE = 2'b00,
    SLEEP_IDLE = 2'b01,
    SLEEP_PWRDN = 2'b10
  } sleep_req_t;

  // fuse programming request from a programming interface
  typedef struct packed {
    logic par_mode;    // parallel programming mode active
    logic ser_mode;    // serial programming mode active
    logic wr_stb;      // write strobe
    logic wr_value;    // value to place in the fuse
  } fuse_prog_t;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic cpu_en;
    logic periph_en;
    logic osc_run;
  } clk_en_t;
endpackage

//--- verilog/clk_rc_divider.sv
/*
 divider making the 1 MHz internal rc oscillator as a one-cycle enable.
 assumes the reference clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module clk_rc_divider #(
  parameter int unsigned DIV = 20
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_run,
  output logic o_tick
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_r;

  // free count while running, pulse on wrap
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule

//--- verilog/clock_source_sleep_reset.sv
/*
 clock source select, idle and power-down sleep, and reset handling.
 assumes all inputs synchronous to i_ref_clk; the pin reset is sampled
 on i_ref_clk and the crystal clock arrives as an enable pulse.
*/
// Behaviour
// - idle stops the cpu; registers, timer, watchdog, interrupts keep running.
// - power-down stops the oscillator; only external interrupt or reset wakes.
// - reset pin low at least 50 ns resets, even with no system clock.
// - while reset is active all port pins are released to high impedance.
// - internal rc oscillator at fixed 1 MHz can clock the processor.
// - fuse reading 0 picks rc oscillator, otherwise the crystal input.
// - fuse leaves the factory at 1, so the crystal is the default source.
// - only parallel programming can change the fuse; serial leaves it alone.
`timescale 1ns/10ps
module clock_source_sleep_reset #(
  parameter int unsigned PORTS = clk_ctrl_pkg::PORT_WIDTH,
  parameter int unsigned RC_DIVIDE = clk_ctrl_pkg::RC_DIV
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_reset_n,
  input wire logic i_xtal_tick,
  input wire clk_ctrl_pkg::sleep_req_t i_sleep_req,
  input wire logic i_ext_irq,
  input wire logic i_any_irq,
  input wire clk_ctrl_pkg::fuse_prog_t i_fuse_prog,
  input wire logic [PORTS-1:0] i_port_oe,
  output logic [PORTS-1:0] o_port_oe,
  output logic o_sys_rst,
  output logic o_sys_clk_en,
  output clk_ctrl_pkg::clk_en_t o_clk_en,
  output logic o_rc_clock_select_fuse,
  output clk_ctrl_pkg::power_state_t o_power_state
);
  import clk_ctrl_pkg::*;

  logic fuse_r;
  logic rc_tick;
  logic sel_tick;
  logic pin_low;
  logic [SYNC_STAGES-1:0] rel_sync_r;
  logic rst_hold_r;
  logic rst_int;
  power_state_t state_r;
  power_state_t state_nxt;
  logic osc_run;

  // the fuse is non-volatile: i_srst models power-on, factory value 1
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      fuse_r <= FUSE_RESET;
    end else if (i_fuse_prog.par_mode && !i_fuse_prog.ser_mode && i_fuse_prog.wr_stb) begin
      fuse_r <= i_fuse_prog.wr_value;
    end
  end

  // oscillator runs unless frozen by power-down
  assign osc_run = (state_r != ST_PWRDN);

  clk_rc_divider #(
    .DIV(RC_DIVIDE)
  ) u_rc_div (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_run(osc_run && (fuse_r == FUSE_PROGRAMMED)),
    .o_tick(rc_tick)
  );

  // clock multiplexer: programmed fuse picks the rc source
  assign sel_tick = osc_run &&
                    ((fuse_r == FUSE_PROGRAMMED) ? rc_tick : i_xtal_tick);

  // pin reset acts at once, without waiting for a system clock tick
  assign pin_low = !i_reset_n;
  assign rst_int = pin_low || rst_hold_r || i_srst;

  // release stretched until the third selected clock tick with pin high
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || pin_low) begin
      rel_sync_r <= '0;
      rst_hold_r <= 1'b1;
    end else if (sel_tick) begin
      rel_sync_r <= {rel_sync_r[SYNC_STAGES-2:0], 1'b1};
      rst_hold_r <= !rel_sync_r[SYNC_STAGES-1];
    end
  end

  // sleep state: idle leaves on any interrupt, power-down only on external
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (sel_tick && i_sleep_req == SLEEP_IDLE) begin
          state_nxt = ST_IDLE;
        end else if (sel_tick && i_sleep_req == SLEEP_PWRDN) begin
          state_nxt = ST_PWRDN;
        end
      end
      ST_IDLE: begin
        if (i_any_irq) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_PWRDN: begin
        if (i_ext_irq) begin
          state_nxt = ST_ACTIVE;
        end
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_int) begin
      state_r <= ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // enables: cpu only when active, peripherals also in idle
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_clk_en <= '0;
      o_sys_clk_en <= 1'b0;
    end else begin
      o_sys_clk_en <= sel_tick;
      o_clk_en.osc_run <= osc_run;
      o_clk_en.cpu_en <= sel_tick && !rst_int && state_nxt == ST_ACTIVE;
      o_clk_en.periph_en <= sel_tick && state_nxt != ST_PWRDN;
    end
  end

  // reset output and port release; the pin clears enables in the same edge
  always_ff @(posedge i_ref_clk) begin
    if (rst_int) begin
      o_sys_rst <= 1'b1;
      o_port_oe <= '0;
    end else begin
      o_sys_rst <= 1'b0;
      o_port_oe <= i_port_oe;
    end
  end

  // fuse and state visible for the programmer and the core
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rc_clock_select_fuse <= FUSE_RESET;
      o_power_state <= ST_ACTIVE;
    end else begin
      o_rc_clock_select_fuse <= fuse_r;
      o_power_state <= state_r;
    end
  end
endmodule

//--- tb/clock_source_sleep_reset_monitor.sv
/*
 assertions on the clock select, sleep and reset block.
 assumes binding to the top ports with the default rc divide of 20.
*/
`timescale 1ns/10ps
module clock_source_sleep_reset_monitor
  import clk_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_reset_n,
  input wire logic i_xtal_tick,
  input wire logic i_ext_irq,
  input wire fuse_prog_t i_fuse_prog,
  input wire logic [14:0] o_port_oe,
  input wire logic o_sys_rst,
  input wire logic o_sys_clk_en,
  input wire clk_en_t o_clk_en,
  input wire logic o_rc_clock_select_fuse,
  input wire power_state_t o_power_state
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  logic wr_ok;
  logic pd;
  // legal fuse write and power-down shorthand
  assign wr_ok = i_fuse_prog.par_mode && !i_fuse_prog.ser_mode && i_fuse_prog.wr_stb;
  assign pd = o_power_state == ST_PWRDN;
  a_port_hiz: assert property (o_sys_rst |-> o_port_oe == '0)
    else $error("port enabled in reset");
  a_pin_reset: assert property (!i_reset_n |=> o_sys_rst && o_port_oe == '0)
    else $error("pin reset missed");
  a_fuse_write: assert property (wr_ok |-> ##2 o_rc_clock_select_fuse == $past(i_fuse_prog.wr_value, 2))
    else $error("fuse write lost");
  a_fuse_hold: assert property (!wr_ok |-> ##2 $stable(o_rc_clock_select_fuse))
    else $error("fuse changed");
  a_rc_period: assert property ((o_sys_clk_en && !o_rc_clock_select_fuse && !pd) |-> ##20 (o_sys_clk_en || pd))
    else $error("rc tick period wrong");
  a_xtal_follow: assert property ((i_xtal_tick && o_rc_clock_select_fuse && !pd) |-> ##[1:2] o_sys_clk_en)
    else $error("crystal tick not passed");
  a_idle_cpu: assert property ((o_power_state == ST_IDLE) |-> !$past(o_clk_en.cpu_en))
    else $error("cpu clocked in idle");
  a_pd_frozen: assert property ((pd && $past(pd)) |-> !o_sys_clk_en && !o_clk_en.osc_run)
    else $error("clock runs in power-down");
  a_pd_wake: assert property ((pd && i_ext_irq) |-> ##[1:3] o_power_state == ST_ACTIVE)
    else $error("no wake from power-down");
endmodule

//--- tb/clock_source_sleep_reset_tb.sv
/*
 self-checking bench for the clock select, sleep and reset block.
 assumes the monitor is compiled first; crystal made as a tick every 4 cycles.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch %0t got %h exp %h", $time, (a), (b)); end end
module clock_source_sleep_reset_tb;
  import clk_ctrl_pkg::*;
  logic i_ref_clk = 0, i_srst = 1, i_reset_n = 1, i_xtal_tick = 0, i_ext_irq = 0, i_any_irq = 0;
  logic o_sys_rst, o_sys_clk_en, o_rc_clock_select_fuse, xtal_on = 1;
  logic [14:0] i_port_oe = 15'h7fff, o_port_oe;
  sleep_req_t i_sleep_req = SLEEP_NONE;
  fuse_prog_t i_fuse_prog = '0;
  clk_en_t o_clk_en;
  power_state_t o_power_state;
  int bad_count = 0, samples_checked = 0, cyc = 0, n, ts, tc, tp;
  clock_source_sleep_reset dut (.*);
  initial forever #25 i_ref_clk = ~i_ref_clk;
  // crystal tick source
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    i_xtal_tick <= xtal_on && (cyc % 4 == 0);
  end
  task automatic test_done;
    $display("bad_count %0d samples_checked %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // count enables over a span
  task automatic watch(input int cycles);
    ts = 0;
    tc = 0;
    tp = 0;
    repeat (cycles) begin
      @(negedge i_ref_clk);
      ts += o_sys_clk_en;
      tc += o_clk_en.cpu_en;
      tp += o_clk_en.periph_en;
    end
  endtask
  task automatic wait_state(input power_state_t s);
    n = 0;
    while (o_power_state !== s && n < 300) begin
      @(negedge i_ref_clk);
      n++;
    end
    `CHK(o_power_state, s)
  endtask
  task automatic prog(input logic [3:0] v);
    @(posedge i_ref_clk);
    i_fuse_prog <= fuse_prog_t'(v);
    @(posedge i_ref_clk);
    i_fuse_prog <= '0;
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task automatic t_reset;
    @(posedge i_ref_clk);
    i_reset_n <= 1'b0;
    @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    `CHK({o_sys_rst, o_port_oe}, 16'h8000)
    n = 0;
    while (o_sys_rst !== 1'b0 && n < 100) begin
      @(negedge i_ref_clk);
      n++;
    end
    `CHK(o_port_oe, 15'h7fff)
  endtask
  task automatic t_fuse;
    @(posedge i_ref_clk);
    xtal_on <= 1'b0;
    prog(4'h6);
    prog(4'he);
    `CHK(o_rc_clock_select_fuse, 1'b1)
    prog(4'ha);
    `CHK(o_rc_clock_select_fuse, 1'b0)
    watch(200);
    `CHK(ts, 10)
  endtask
  task automatic t_sleep;
    @(posedge i_ref_clk);
    i_sleep_req <= SLEEP_IDLE;
    wait_state(ST_IDLE);
    @(posedge i_ref_clk);
    i_sleep_req <= SLEEP_NONE;
    watch(100);
    `CHK({tc == 0, tp > 0}, 2'h3)
    @(posedge i_ref_clk);
    i_any_irq <= 1'b1;
    wait_state(ST_ACTIVE);
    @(posedge i_ref_clk);
    i_sleep_req <= SLEEP_PWRDN;
    i_any_irq <= 1'b0;
    wait_state(ST_PWRDN);
    @(posedge i_ref_clk);
    i_sleep_req <= SLEEP_NONE;
    i_any_irq <= 1'b1;
    watch(100);
    `CHK({ts == 0, o_power_state}, {1'b1, ST_PWRDN})
    @(posedge i_ref_clk);
    i_any_irq <= 1'b0;
    i_ext_irq <= 1'b1;
    wait_state(ST_ACTIVE);
    @(posedge i_ref_clk);
    i_ext_irq <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    repeat (2) @(negedge i_ref_clk);
    `CHK({o_rc_clock_select_fuse, o_power_state}, {FUSE_RESET, ST_ACTIVE})
    t_reset;
    t_fuse;
    t_sleep;
    test_done;
  end
  // hang guard
  initial begin
    #500000;
    bad_count++;
    test_done;
  end
endmodule
bind clock_source_sleep_reset clock_source_sleep_reset_monitor mon (.*);
